// ===== hw/nbbs_sequencer.sv
// Notes on behaviour
// - Burst is one address, two to four data
// - 8-bit bursts start at offsets 0-2 only
// - 8-bit offset 1: three-byte burst, one byte
// - 8-bit offset 2: two two-byte bursts
// - 8-bit offset 3: one byte, three-byte burst
// - 16-bit bursts may mix byte and short
// - 16-bit offset 1: byte+short burst, byte
// - 16-bit offset 2: two separate shorts
// - 16-bit offset 3: byte, short+byte burst
`include "nbbs_cfg.svh"
`default_nettype none
module nbbs_sequencer
  import nbbs_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rstn_i,
  // Word request (same clock)
  input  wire logic               req_valid_i,
  output logic                    req_ready_o,
  input  wire logic               width16_i,
  input  wire logic [1:0]         ofs_i,
  // External bus
  output logic                    addr_cycle_o,
  output logic                    data_cycle_o,
  output logic                    burst_last_o,
  output logic [1:0]              low_byte_address_bits_o,
  output nbbs_pkg::nbbs_dtype_e   data_type_o,
  output logic                    lane3_byte_enable_n_o,
  output logic                    lane2_byte_enable_n_o,
  output logic                    lane1_byte_enable_n_o,
  output logic                    lane0_byte_enable_n_o,
  input  wire logic               data_ack_i,
  output logic                    word_done_o
);
  import nbbs_pkg::*;

  typedef enum logic [1:0] {
    NBBS_ST_IDLE = 2'h0,
    NBBS_ST_ADDR = 2'h1,
    NBBS_ST_DATA = 2'h2
  } nbbs_state_e;

  // All sequencer state in one record
  typedef struct packed {
    nbbs_state_e st;      // Phase
    logic        w16;     // Latched bus width
    logic [1:0]  addr;    // Current byte offset
    logic [2:0]  left;    // Data cycles left in this access
    logic        second;  // Working on second access
    logic [2:0]  len1;    // Length of second access
    logic        more;    // A second access follows
    logic        done;    // Word finished pulse
    logic [2:0]  bytes_left;  // Bytes of the word still to move
  } nbbs_state_s;

  nbbs_state_s st_ff;     // Registered state
  nbbs_state_s nxt_st;    // Next state
  nbbs_plan_if plan ();   // Split plan for the live request

  // ----------------------------------------
  // Planner
  // ----------------------------------------
  nbbs_planner nbbs_planner_inst (
    .width16_i (width16_i),
    .ofs_i     (ofs_i),
    .plan      (plan)
  );

  // One data cycle moves a byte, or a short from an even offset on 16-bit
  // A short is only used while two or more bytes of the word remain; otherwise
  // the tail of an unaligned word would spill one byte into the next word
  function automatic logic is_short(input logic w16, input logic [1:0] a, input logic [2:0] n);
    is_short = w16 && !a[0] && (n >= 3'h2);
  endfunction : is_short

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.st)
      NBBS_ST_IDLE: begin
        if (req_valid_i) begin
          nxt_st.st     = NBBS_ST_ADDR;
          nxt_st.w16    = width16_i;
          nxt_st.addr   = ofs_i;
          nxt_st.left   = plan.len0;
          nxt_st.len1   = plan.len1;
          nxt_st.more   = (plan.n_acc == 2'h2);
          nxt_st.second = 1'b0;
          // Whole word still to move
          nxt_st.bytes_left = `NBBS_WORD_BYTES;
        end
      end
      // Single address cycle opens each access
      NBBS_ST_ADDR: nxt_st.st = NBBS_ST_DATA;
      NBBS_ST_DATA: begin
        if (data_ack_i) begin
          // Advance the offset on every acknowledged data cycle
          nxt_st.addr = st_ff.addr + (is_short(st_ff.w16, st_ff.addr, st_ff.bytes_left) ? 2'h2 : 2'h1);
          // Bytes moved by this beat leave the word count
          nxt_st.bytes_left = st_ff.bytes_left - (is_short(st_ff.w16, st_ff.addr, st_ff.bytes_left) ? 3'h2 : 3'h1);
          nxt_st.left = st_ff.left - 3'h1;
          if (st_ff.left == 3'h1) begin
            if (st_ff.more && !st_ff.second) begin
              nxt_st.st     = NBBS_ST_ADDR;
              nxt_st.second = 1'b1;
              nxt_st.left   = st_ff.len1;
            end else begin
              nxt_st.st   = NBBS_ST_IDLE;
              nxt_st.done = 1'b1;
            end
          end
        end
      end
      default: nxt_st.st = NBBS_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '{st: NBBS_ST_IDLE, w16: 1'b0, addr: 2'h0, left: 3'h0,
                 second: 1'b0, len1: 3'h0, more: 1'b0, done: 1'b0, bytes_left: 3'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Enables are decoded live from the current offset, never held from the first cycle
  logic short_now;   // Current data cycle carries a short
  always_comb begin
    short_now               = is_short(st_ff.w16, st_ff.addr, st_ff.bytes_left);
    req_ready_o             = (st_ff.st == NBBS_ST_IDLE);
    addr_cycle_o            = (st_ff.st == NBBS_ST_ADDR);
    data_cycle_o            = (st_ff.st == NBBS_ST_DATA);
    burst_last_o            = data_cycle_o && (st_ff.left == 3'h1);
    low_byte_address_bits_o = st_ff.addr;
    data_type_o             = short_now ? NBBS_DT_SHORT : NBBS_DT_BYTE;
    lane0_byte_enable_n_o   = !(data_cycle_o && st_ff.addr == 2'h0);
    lane1_byte_enable_n_o   = !(data_cycle_o && (st_ff.addr == 2'h1 || (short_now && st_ff.addr == 2'h0)));
    lane2_byte_enable_n_o   = !(data_cycle_o && st_ff.addr == 2'h2);
    lane3_byte_enable_n_o   = !(data_cycle_o && (st_ff.addr == 2'h3 || (short_now && st_ff.addr == 2'h2)));
    word_done_o             = st_ff.done;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  burst_len_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st_ff.st == NBBS_ST_ADDR) |-> (st_ff.left >= 3'h1 && st_ff.left <= `NBBS_MAX_BURST))
    else $error("access length out of range");
  single_at3_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st_ff.st == NBBS_ST_ADDR && !st_ff.w16 && st_ff.addr == `NBBS_OFS_SINGLE8) |-> st_ff.left == 3'h1)
    else $error("8-bit burst started at offset 3");
  ofs1_8_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_ready_o && req_valid_i && !width16_i && ofs_i == 2'h1) |=> st_ff.left == 3'h3 && st_ff.len1 == 3'h1)
    else $error("offset 1 split wrong on 8-bit");
  ofs2_8_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_ready_o && req_valid_i && !width16_i && ofs_i == 2'h2) |=> st_ff.left == 3'h2 && st_ff.len1 == 3'h2)
    else $error("offset 2 split wrong on 8-bit");
  ofs3_8_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_ready_o && req_valid_i && !width16_i && ofs_i == 2'h3) |=> st_ff.left == 3'h1 && st_ff.len1 == 3'h3)
    else $error("offset 3 split wrong on 8-bit");
  ofs1_16_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_ready_o && req_valid_i && width16_i && ofs_i == 2'h1) |=> st_ff.left == 3'h2 && st_ff.len1 == 3'h1)
    else $error("offset 1 split wrong on 16-bit");
  ofs2_16_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_ready_o && req_valid_i && width16_i && ofs_i == 2'h2) |=> st_ff.left == 3'h1 && st_ff.more)
    else $error("offset 2 split wrong on 16-bit");
  ofs3_16_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_ready_o && req_valid_i && width16_i && ofs_i == 2'h3) |=> st_ff.left == 3'h1 && st_ff.len1 == 3'h2)
    else $error("offset 3 split wrong on 16-bit");
  addr_step_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (data_cycle_o && data_ack_i && !burst_last_o) |=>
      low_byte_address_bits_o == $past(low_byte_address_bits_o) + ($past(short_now) ? 2'h2 : 2'h1))
    else $error("low address did not advance");
  // Shorts only on a 16-bit bus and only from an even offset
  type_mix_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (data_cycle_o && data_type_o == NBBS_DT_SHORT) |-> (st_ff.w16 && !low_byte_address_bits_o[0]))
    else $error("short beat on byte bus or odd offset");
  // A finished word has moved exactly its four bytes, no spill into the next word
  word_bytes_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    st_ff.done |-> (st_ff.bytes_left == 3'h0))
    else $error("word ended with bytes over or under");
  // Enables are all released outside data cycles
  lanes_idle_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !data_cycle_o |-> (lane0_byte_enable_n_o && lane1_byte_enable_n_o && lane2_byte_enable_n_o
                       && lane3_byte_enable_n_o))
    else $error("byte enable active outside data cycle");
endmodule : nbbs_sequencer
`default_nettype wire

// ===== shared/nbbs_cfg.svh
`ifndef NBBS_CFG_SVH
`define NBBS_CFG_SVH
// ----------------------------------------
// Bus width codes and burst limits
// ----------------------------------------
`define NBBS_WIDTH_8       1'b0
`define NBBS_WIDTH_16      1'b1
`define NBBS_MIN_BURST     3'h2
`define NBBS_MAX_BURST     3'h4
`define NBBS_OFS_SINGLE8   2'h3
`define NBBS_WORD_BYTES    3'h4
`endif

// ===== shared/nbbs_pkg.sv
`default_nettype none
package nbbs_pkg;
  // Data type of one data cycle
  typedef enum logic [1:0] {
    NBBS_DT_BYTE  = 2'h0,
    NBBS_DT_SHORT = 2'h1
  } nbbs_dtype_e;
endpackage : nbbs_pkg
`default_nettype wire

// ===== shared/nbbs_plan_if.sv
`default_nettype none
// Carries one precomputed access plan from planner to sequencer
interface nbbs_plan_if;
  logic [1:0] n_acc;     // Number of accesses, 1 or 2
  logic [2:0] len0;      // Data cycles in access 0
  logic [2:0] len1;      // Data cycles in access 1
  modport planner (output n_acc, output len0, output len1);
  modport user    (input n_acc, input len0, input len1);
endinterface : nbbs_plan_if
`default_nettype wire

// ===== hw/nbbs_planner.sv
`include "nbbs_cfg.svh"
`default_nettype none
// Splits a word access into accesses from the bus width and start offset
module nbbs_planner (
  // Request
  input  wire logic       width16_i,
  input  wire logic [1:0] ofs_i,
  // Plan
  nbbs_plan_if.planner    plan
);
  // ----------------------------------------
  // Split table
  // ----------------------------------------
  // Lengths count data cycles; on 16-bit a byte and a short are one cycle each
  always_comb begin
    plan.n_acc = 2'h2;
    plan.len0  = 3'h1;
    plan.len1  = 3'h1;
    if (width16_i == `NBBS_WIDTH_8) begin
      case (ofs_i)
        2'h0: begin plan.n_acc = 2'h1; plan.len0 = 3'h4; end
        2'h1: begin plan.len0 = 3'h3; plan.len1 = 3'h1; end
        2'h2: begin plan.len0 = 3'h2; plan.len1 = 3'h2; end
        default: begin plan.len0 = 3'h1; plan.len1 = 3'h3; end
      endcase
    end else begin
      case (ofs_i)
        2'h0: begin plan.n_acc = 2'h1; plan.len0 = 3'h2; end
        2'h1: begin plan.len0 = 3'h2; plan.len1 = 3'h1; end
        2'h2: begin plan.len0 = 3'h1; plan.len1 = 3'h1; end
        default: begin plan.len0 = 3'h1; plan.len1 = 3'h2; end
      endcase
    end
  end
endmodule : nbbs_planner
`default_nettype wire

// ===== sim/nbbs_mem_model.sv
`default_nettype none
// ----------------------------------------
// Narrow memory controller model
// ----------------------------------------
module nbbs_mem_model
  import nbbs_pkg::*;
(
  // Clock, reset and pace
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  slow_i,
  // Bus from the sequencer
  input  wire logic                  data_cycle_i,
  input  wire logic                  burst_last_i,
  input  wire logic [1:0]            low_byte_address_bits_i,
  input  wire nbbs_pkg::nbbs_dtype_e data_type_i,
  input  wire logic [3:0]            lane_enable_n_i,
  output logic                       data_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;  // Stall cycles spent on this beat
  logic [7:0] log_q[$]; // Accepted beats, read and cleared by the bench
  // Slow pace stalls each beat two cycles, so stale outputs show up
  assign data_ack_o = data_cycle_i & (!slow_i | wait_ff == 2'h2);
  // No address counter, only the stall count: lane and address are taken live at each ack
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= (data_ack_o | !data_cycle_i) ? 2'h0 : wait_ff + 2'h1;
    end
  end
  // Log in a plain process, since the bench also clears the queue
  always @(posedge core_clk_i) begin
    if (rstn_i && data_ack_o) log_q.push_back({burst_last_i, data_type_i[0], low_byte_address_bits_i, lane_enable_n_i});
  end
endmodule : nbbs_mem_model
`default_nettype wire

// ===== sim/test_narrow_bus_burst_sequencer.sv
`default_nettype none
module test_narrow_bus_burst_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import nbbs_pkg::*;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic        core_clk_i, rstn_i, req_valid_i, width16_i, slow;
  logic [1:0]  ofs_i, low_byte_address_bits_o;
  logic        req_ready_o, addr_cycle_o, data_cycle_o, burst_last_o, data_ack_i, word_done_o;
  logic [3:0]  be_n;        // Lane enables, lane 3 on top
  nbbs_dtype_e data_type_o;
  int          failures, cmp_count, acc_cnt, cyc;
  nbbs_sequencer nbbs_sequencer_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .width16_i(width16_i), .ofs_i(ofs_i), .addr_cycle_o(addr_cycle_o),
    .data_cycle_o(data_cycle_o), .burst_last_o(burst_last_o), .low_byte_address_bits_o(low_byte_address_bits_o),
    .data_type_o(data_type_o), .lane3_byte_enable_n_o(be_n[3]), .lane2_byte_enable_n_o(be_n[2]),
    .lane1_byte_enable_n_o(be_n[1]), .lane0_byte_enable_n_o(be_n[0]), .data_ack_i(data_ack_i),
    .word_done_o(word_done_o));
  nbbs_mem_model nbbs_mem_model_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .data_cycle_i(data_cycle_o), .burst_last_i(burst_last_o), .low_byte_address_bits_i(low_byte_address_bits_o),
    .data_type_i(data_type_o), .lane_enable_n_i(be_n), .data_ack_o(data_ack_i));
  // 125 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // Count address cycles; cut a hang short well past the expected run
  always @(posedge core_clk_i) begin
    if (addr_cycle_o === 1'b1) acc_cnt++;
    cyc++;
    if (cyc == 5000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Beat code: last, short, low address, enables (short uses a lane pair)
  function automatic logic [7:0] bt(input logic l, input logic s, input logic [1:0] a);
    return {l, s, a, s ? (a == 2'h0 ? 4'hC : 4'h3) : ~(4'h1 << a)};
  endfunction : bt
  // Byte bus: addresses climb and every access closes at lane 3 or word end
  function automatic logic [31:0] exp8(input logic [1:0] o);
    logic [1:0] a;
    for (int i = 0; i < 4; i++) begin
      a = o + 2'(i);
      exp8[8*i +: 8] = bt(a == 2'h3 || i == 3, 1'b0, a);
    end
  endfunction : exp8
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic check_log(input int base, input int n, input logic [31:0] e);
    for (int k = 0; k < n; k++) check(nbbs_mem_model_inst.log_q[base + k], e[8*k +: 8]);
  endtask : check_log
  // Done pulses for one cycle, so poll it at every falling edge
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(negedge core_clk_i);
      k++;
    end while (word_done_o !== 1'b1 && k < 200);
    check({6'h0, word_done_o, req_ready_o}, 8'h03);
  endtask : wait_done
  // One word; address cycles must equal the number of closing beats
  task automatic run_word(input logic w, input logic [1:0] o, input int n, input logic [31:0] e);
    int na;
    na = 0;
    for (int k = 0; k < n; k++) na += int'(e[8*k+7]);
    @(negedge core_clk_i);
    nbbs_mem_model_inst.log_q.delete();
    acc_cnt = 0;
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    width16_i   <= w;
    ofs_i       <= o;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    wait_done();
    check(8'(nbbs_mem_model_inst.log_q.size()), 8'(n));
    check_log(0, n, e);
    check(8'(acc_cnt), 8'(na));
  endtask : run_word
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_bus8();
    for (int o = 0; o < 4; o++) run_word(1'b0, 2'(o), 4, exp8(2'(o)));
    $display("test_bus8 done");
  endtask : test_bus8
  // Slow memory: outputs must hold until each ack
  task automatic test_bus16();
    slow = 1'b1;
    run_word(1'b1, 2'h0, 2, 32'({bt(1'b1, 1'b1, 2'h2), bt(1'b0, 1'b1, 2'h0)}));
    run_word(1'b1, 2'h1, 3, 32'({bt(1'b1, 1'b0, 2'h0), bt(1'b1, 1'b1, 2'h2), bt(1'b0, 1'b0, 2'h1)}));
    run_word(1'b1, 2'h2, 2, 32'({bt(1'b1, 1'b1, 2'h0), bt(1'b1, 1'b1, 2'h2)}));
    run_word(1'b1, 2'h3, 3, 32'({bt(1'b1, 1'b0, 2'h2), bt(1'b0, 1'b1, 2'h0), bt(1'b1, 1'b0, 2'h3)}));
    slow = 1'b0;
    $display("test_bus16 done");
  endtask : test_bus16
  // Request held while busy is only taken once done; offset sampled at take
  task automatic test_back_to_back();
    @(negedge core_clk_i);
    nbbs_mem_model_inst.log_q.delete();
    acc_cnt = 0;
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    width16_i   <= 1'b0;
    ofs_i       <= 2'h0;
    @(posedge core_clk_i);
    ofs_i <= 2'h3;
    wait_done();
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    wait_done();
    check(8'(nbbs_mem_model_inst.log_q.size()), 8'h08);
    check_log(0, 4, exp8(2'h0));
    check_log(4, 4, exp8(2'h3));
    check(8'(acc_cnt), 8'h03);
    $display("test_back_to_back done");
  endtask : test_back_to_back
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // Main sequence after four reset cycles
  initial begin
    rstn_i      = 1'b0;
    req_valid_i = 1'b0;
    width16_i   = 1'b0;
    ofs_i       = 2'h0;
    slow        = 1'b0;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    test_bus8();
    test_bus16();
    test_back_to_back();
    final_report();
  end
endmodule : test_narrow_bus_burst_sequencer
`default_nettype wire
